/* inc/ftam_map.svh */
// Register select codes, bit positions, reset values and timing figures of the fan
// tachometer and alarm monitor.
// Assumes a 100 MHz system clock and an 8-bit register port.
`ifndef FTAM_MAP_SVH
`define FTAM_MAP_SVH

`define FTAM_SEL_PIN 4'h0
`define FTAM_SEL_ENABLE 4'h1
`define FTAM_SEL_FLAGS 4'h2
`define FTAM_SEL_WINDOW 4'h3
`define FTAM_SEL_DRIVE 4'h4
`define FTAM_SEL_COUNT_BIT 3

`define FTAM_BIT_PIN2 4
`define FTAM_BIT_PIN1 3
`define FTAM_BIT_OVF 2
`define FTAM_BIT_MIN 1
`define FTAM_BIT_MAX 0

`define FTAM_RST_PIN 5'h1f
`define FTAM_RST_ENABLE 5'h00
`define FTAM_RST_FLAGS 5'h00
`define FTAM_RST_WINDOW 2'h2
`define FTAM_RST_COUNT 8'h00
`define FTAM_RST_DRIVE 8'h00
`define FTAM_COUNT_MAX 8'hff
`define FTAM_ZERO3 3'h0
`define FTAM_ZERO6 6'h00

`define FTAM_CLK_NS 10
`define FTAM_QUARTER_NS 250000000

`endif

/* inc/ftam_pkg.sv */
// Types shared by the fan tachometer and alarm monitor.
// Assumes the map header supplies all numeric constants.
package ftam_pkg;
   typedef enum logic [1:0] {
      FTAM_FULL_ON,
      FTAM_OFF,
      FTAM_CLOSED,
      FTAM_OPEN
   } ftam_mode_t;

   typedef logic [4:0] ftam_alarm_t;
   typedef logic [7:0] ftam_byte_t;
endpackage

/* rtl/ftam_window_timer.sv */
// Count window timer: one-cycle pulse at the end of every window.
// Assumes the window code is stable for the length of a window.
`timescale 1ns/1ps
`include "ftam_map.svh"
module ftam_window_timer #(
   parameter int unsigned QUARTER_CYCLES = `FTAM_QUARTER_NS / `FTAM_CLK_NS
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [1:0] count_window_code,
   output logic window_end
);
   logic [31:0] count;
   logic [31:0] next_count;
   logic [31:0] length;
   logic next_window_end;

   // Windows run back to back; the length is the quarter-second count doubled per code step.
   always_comb begin
      length = QUARTER_CYCLES << count_window_code;
      next_window_end = 1'b0;
      next_count = count + 32'h1;
      if (count >= length - 32'h1) begin
         next_window_end = 1'b1;
         next_count = 32'h0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         count <= 32'h0;
         window_end <= 1'b0;
      end else begin
         count <= next_count;
         window_end <= next_window_end;
      end
   end
endmodule

/* rtl/ftam_top.sv */
// Fan tachometer counters, alarm enable and status, pin status and drive level register.
// Assumes a serial bus front end drives the register port and all inputs are synchronous.
//
// Function
// - Pin status reads zero in bits 7..5, live pin levels 4..0, ones after reset.
// - Each tachometer input counts pulses over the window into its count register.
// - Four tachometer inputs, each with its own count register.
// - Too many pulses saturate the count at 255 and set the overflow alarm.
// - Window register reads zero above bit 1; window is 0.25 s times 2^code.
// - Reset clears all counts and selects a one second window.
// - Enable register: pin2, pin1, overflow, min, max bits; reset zero; upper bits zero.
// - Status register uses enable bit positions; upper bits zero; reset zero.
// - Pin-1 and pin-2 alarms are set while those pins are low.
// - A status read clears set bits whose condition has gone; persisting ones stay.
// - Drive level steers the fan only in open-loop mode; ignored in closed loop.
// - Reset clears enable, status, count and drive registers and disables all alarms.
// - An alarm takes effect and drives the alert only when enabled.
// - Minimum and maximum level alarms work only in closed-loop mode.
// - Alert pin is driven low on an enabled fault, released when the read clears it.
`timescale 1ns/1ps
`include "ftam_map.svh"
module ftam_top #(
   parameter int unsigned QUARTER_CYCLES = `FTAM_QUARTER_NS / `FTAM_CLK_NS
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [3:0] speed_pulse_overflow_in,
   input wire logic [4:0] gpio_in,
   input wire logic [1:0] op_mode,
   input wire logic level_at_min,
   input wire logic level_at_max,
   input wire logic alert_select,
   input wire logic [3:0] reg_sel,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic [7:0] drive_level_out,
   output logic general_io_zero_out,
   output logic general_io_zero_oe_n
);
   logic window_end;
   logic [3:0] speed_pulse_overflow_prev;
   logic [3:0] speed_pulse_overflow_edge;
   logic [7:0] acc [4];
   logic [7:0] next_acc [4];
   logic [3:0] acc_ovf;
   logic [3:0] next_acc_ovf;
   logic [7:0] pulse_count [4];
   logic [7:0] next_pulse_count [4];
   logic ovf_window;
   logic next_ovf_window;
   logic ovf_event;
   logic [4:0] pin_level;
   ftam_pkg::ftam_alarm_t alarm_enable_mask;
   ftam_pkg::ftam_alarm_t next_alarm_enable_mask;
   ftam_pkg::ftam_alarm_t alarm_flags;
   ftam_pkg::ftam_alarm_t next_alarm_flags;
   ftam_pkg::ftam_alarm_t cond;
   logic [1:0] count_window_code;
   logic [1:0] next_count_window_code;
   ftam_pkg::ftam_byte_t drive_level_code;
   ftam_pkg::ftam_byte_t next_drive_level_code;
   ftam_pkg::ftam_byte_t next_drive_level_out;
   ftam_pkg::ftam_byte_t next_reg_rdata;
   logic closed_loop;
   logic flags_read;

   ftam_window_timer #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_timer (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .count_window_code(count_window_code),
      .window_end(window_end)
   );

   assign speed_pulse_overflow_edge = speed_pulse_overflow_in & ~speed_pulse_overflow_prev;
   assign closed_loop = (ftam_pkg::ftam_mode_t'(op_mode) == ftam_pkg::FTAM_CLOSED);
   assign flags_read = reg_rd && (reg_sel == `FTAM_SEL_FLAGS);

   // Per-channel pulse counters with saturation.
   generate
      for (genvar i = 0; i < 4; i++) begin : g_speed_pulse_overflow
         always_comb begin
            next_acc[i] = acc[i];
            next_acc_ovf[i] = acc_ovf[i];
            next_pulse_count[i] = pulse_count[i];
            if (speed_pulse_overflow_edge[i]) begin
               if (acc[i] == `FTAM_COUNT_MAX) begin
                  next_acc_ovf[i] = 1'b1;
               end else begin
                  next_acc[i] = acc[i] + 8'h01;
               end
            end
            if (window_end) begin
               next_pulse_count[i] = acc[i];
               next_acc[i] = {7'h00, speed_pulse_overflow_edge[i]};
               next_acc_ovf[i] = 1'b0;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               acc[i] <= `FTAM_RST_COUNT;
               acc_ovf[i] <= 1'b0;
               pulse_count[i] <= `FTAM_RST_COUNT;
            end else begin
               acc[i] <= next_acc[i];
               acc_ovf[i] <= next_acc_ovf[i];
               pulse_count[i] <= next_pulse_count[i];
            end
         end
      end
   endgenerate

   // Overflow persists while the last full window or the current one overflowed.
   always_comb begin
      ovf_event = 1'b0;
      for (int j = 0; j < 4; j++) begin
         ovf_event = ovf_event | (speed_pulse_overflow_edge[j] && acc[j] == `FTAM_COUNT_MAX);
      end
      next_ovf_window = ovf_window;
      if (window_end) begin
         next_ovf_window = |acc_ovf;
      end
      cond = `FTAM_RST_FLAGS;
      cond[`FTAM_BIT_PIN2] = ~gpio_in[2];
      cond[`FTAM_BIT_PIN1] = ~gpio_in[1];
      cond[`FTAM_BIT_OVF] = ovf_event | ovf_window | (|acc_ovf);
      cond[`FTAM_BIT_MIN] = level_at_min & closed_loop;
      cond[`FTAM_BIT_MAX] = level_at_max & closed_loop;
   end

   // Register writes, alarm flags, drive output and read data.
   always_comb begin
      next_alarm_enable_mask = alarm_enable_mask;
      next_count_window_code = count_window_code;
      next_drive_level_code = drive_level_code;
      if (reg_wr) begin
         unique case (reg_sel)
            `FTAM_SEL_ENABLE: next_alarm_enable_mask = reg_wdata[4:0];
            `FTAM_SEL_WINDOW: next_count_window_code = reg_wdata[1:0];
            `FTAM_SEL_DRIVE: next_drive_level_code = reg_wdata;
            default: next_alarm_enable_mask = alarm_enable_mask;
         endcase
      end
      if (flags_read) begin
         next_alarm_flags = cond & alarm_enable_mask;
      end else begin
         next_alarm_flags = alarm_flags | (cond & alarm_enable_mask);
      end
      next_drive_level_out = drive_level_out;
      if (ftam_pkg::ftam_mode_t'(op_mode) == ftam_pkg::FTAM_OPEN) begin
         next_drive_level_out = drive_level_code;
      end
      next_reg_rdata = reg_rdata;
      if (reg_rd) begin
         next_reg_rdata = 8'h00;
         if (reg_sel[`FTAM_SEL_COUNT_BIT]) begin
            next_reg_rdata = pulse_count[reg_sel[1:0]];
         end else begin
            unique case (reg_sel)
               `FTAM_SEL_PIN: next_reg_rdata = {`FTAM_ZERO3, pin_level};
               `FTAM_SEL_ENABLE: next_reg_rdata = {`FTAM_ZERO3, alarm_enable_mask};
               `FTAM_SEL_FLAGS: next_reg_rdata = {`FTAM_ZERO3, alarm_flags};
               `FTAM_SEL_WINDOW: next_reg_rdata = {`FTAM_ZERO6, count_window_code};
               `FTAM_SEL_DRIVE: next_reg_rdata = drive_level_code;
               default: next_reg_rdata = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         speed_pulse_overflow_prev <= 4'h0;
         ovf_window <= 1'b0;
         pin_level <= `FTAM_RST_PIN;
         alarm_enable_mask <= `FTAM_RST_ENABLE;
         alarm_flags <= `FTAM_RST_FLAGS;
         count_window_code <= `FTAM_RST_WINDOW;
         drive_level_code <= `FTAM_RST_DRIVE;
         drive_level_out <= `FTAM_RST_DRIVE;
         reg_rdata <= 8'h00;
         general_io_zero_out <= 1'b0;
         general_io_zero_oe_n <= 1'b1;
      end else begin
         speed_pulse_overflow_prev <= speed_pulse_overflow_in;
         ovf_window <= next_ovf_window;
         pin_level <= gpio_in;
         alarm_enable_mask <= next_alarm_enable_mask;
         alarm_flags <= next_alarm_flags;
         count_window_code <= next_count_window_code;
         drive_level_code <= next_drive_level_code;
         drive_level_out <= next_drive_level_out;
         reg_rdata <= next_reg_rdata;
         general_io_zero_out <= 1'b0;
         general_io_zero_oe_n <= ~(alert_select & (|next_alarm_flags));
      end
   end

   // Checks on the block's own behaviour.
   sequence s_pin_read;
      reg_rd && reg_sel == `FTAM_SEL_PIN;
   endsequence
   property p_pin_status;
      @(posedge clk_sys) disable iff (!rstn)
      s_pin_read |=> reg_rdata == {`FTAM_ZERO3, $past(pin_level)};
   endproperty
   a_pin_status: assert property (p_pin_status) else $error("Pin status read wrong.");

   property p_count_update;
      @(posedge clk_sys) disable iff (!rstn)
      window_end |=> pulse_count[0] == $past(acc[0]);
   endproperty
   a_count_update: assert property (p_count_update) else $error("Count not updated.");

   sequence s_ovf_hit;
      speed_pulse_overflow_edge[0] && acc[0] == `FTAM_COUNT_MAX && alarm_enable_mask[`FTAM_BIT_OVF];
   endsequence
   property p_ovf_alarm;
      @(posedge clk_sys) disable iff (!rstn)
      s_ovf_hit |=> alarm_flags[`FTAM_BIT_OVF]
         && (acc[0] == `FTAM_COUNT_MAX || $past(window_end));
   endproperty
   a_ovf_alarm: assert property (p_ovf_alarm) else $error("Overflow alarm missed.");

   property p_window_reset;
      @(posedge clk_sys)
      !rstn |=> count_window_code == `FTAM_RST_WINDOW && pulse_count[2] == `FTAM_RST_COUNT;
   endproperty
   a_window_reset: assert property (p_window_reset) else $error("Reset values wrong.");

   property p_enable_gate;
      @(posedge clk_sys) disable iff (!rstn)
      $rose(alarm_flags[`FTAM_BIT_PIN1]) |-> $past(alarm_enable_mask[`FTAM_BIT_PIN1]);
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("Disabled alarm set.");

   property p_pin1_alarm;
      @(posedge clk_sys) disable iff (!rstn)
      alarm_enable_mask[`FTAM_BIT_PIN1] && !gpio_in[1] |=> alarm_flags[`FTAM_BIT_PIN1];
   endproperty
   a_pin1_alarm: assert property (p_pin1_alarm) else $error("Pin alarm not set.");

   property p_sticky;
      @(posedge clk_sys) disable iff (!rstn)
      alarm_flags[`FTAM_BIT_PIN2] && !flags_read |=> alarm_flags[`FTAM_BIT_PIN2];
   endproperty
   a_sticky: assert property (p_sticky) else $error("Alarm bit lost early.");

   property p_read_clear;
      @(posedge clk_sys) disable iff (!rstn)
      flags_read && gpio_in[1] |=> !alarm_flags[`FTAM_BIT_PIN1];
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("Alarm not cleared.");

   property p_minmax_mode;
      @(posedge clk_sys) disable iff (!rstn)
      $rose(alarm_flags[`FTAM_BIT_MIN]) |-> $past(closed_loop);
   endproperty
   a_minmax_mode: assert property (p_minmax_mode) else $error("Min alarm outside loop.");

   property p_alert;
      @(posedge clk_sys) disable iff (!rstn)
      alert_select && (|alarm_flags) && !flags_read |=> !general_io_zero_oe_n;
   endproperty
   a_alert: assert property (p_alert) else $error("Alert not driven.");

   property p_drive_ignored;
      @(posedge clk_sys) disable iff (!rstn)
      closed_loop[*2] |-> $stable(drive_level_out);
   endproperty
   a_drive_ignored: assert property (p_drive_ignored) else $error("Drive moved in loop.");
endmodule

/* dv/ftam_fan_model.sv */
// Fan model: square tachometer wave whose period is set in clock cycles.
// Assumes a period of zero means a stopped fan and periods stay at two or more.
`timescale 1ns/1ps
module ftam_fan_model (
   input wire logic clk_sys,
   input wire logic [7:0] period,
   output logic speed_pulse_overflow
);
   logic [7:0] phase = 8'h00;
   always @(posedge clk_sys) begin
      phase <= (phase + 8'h01 >= period) ? 8'h00 : phase + 8'h01;
   end
   assign speed_pulse_overflow = (period != 8'h00) && (phase < (period >> 1));
endmodule

/* dv/tb_fan_speed_pulse_overflow_alarm_monitor.sv */
// Self-checking bench for the fan tachometer and alarm monitor with four fan models.
// Assumes the register map header and a shortened quarter window.
`timescale 1ns/1ps
`include "ftam_map.svh"
module tb_fan_speed_pulse_overflow_alarm_monitor;
   localparam int unsigned QC = 150;
   typedef struct {logic [3:0] sel; ftam_pkg::ftam_byte_t exp;} ftam_row_t;
   ftam_row_t rows [9];
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] speed_pulse_overflow_in;
   logic [4:0] gpio_in = 5'h1f;
   logic [1:0] op_mode = 2'h0;
   logic level_at_min = 1'b0;
   logic level_at_max = 1'b0;
   logic alert_select = 1'b1;
   logic [3:0] reg_sel = 4'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [7:0] drive_level_out;
   logic general_io_zero_out;
   logic general_io_zero_oe_n;
   logic [7:0] fan_period [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   int miscompares = 0;
   int samples_checked = 0;
   int unsigned cycles = 0;

   always #5 clk_sys = ~clk_sys;

   for (genvar i = 0; i < 4; i++) begin : g_fan
      ftam_fan_model u_fan (.clk_sys(clk_sys), .period(fan_period[i]), .speed_pulse_overflow(speed_pulse_overflow_in[i]));
   end

   ftam_top #(.QUARTER_CYCLES(QC)) u_dut (
      .clk_sys(clk_sys), .rstn(rstn), .speed_pulse_overflow_in(speed_pulse_overflow_in), .gpio_in(gpio_in),
      .op_mode(op_mode), .level_at_min(level_at_min), .level_at_max(level_at_max),
      .alert_select(alert_select), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .drive_level_out(drive_level_out),
      .general_io_zero_out(general_io_zero_out),
      .general_io_zero_oe_n(general_io_zero_oe_n)
   );

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input ftam_pkg::ftam_byte_t seen,
                      input ftam_pkg::ftam_byte_t exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] s, input ftam_pkg::ftam_byte_t d);
      @(posedge clk_sys);
      reg_sel <= s;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rchk(input string name, input logic [3:0] s, input ftam_pkg::ftam_byte_t exp);
      @(posedge clk_sys);
      reg_sel <= s;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk(name, reg_rdata, exp);
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 70000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      rows = '{'{`FTAM_SEL_PIN, 8'h1f}, '{`FTAM_SEL_ENABLE, 8'h00}, '{`FTAM_SEL_FLAGS, 8'h00},
               '{`FTAM_SEL_WINDOW, 8'h02}, '{`FTAM_SEL_DRIVE, 8'h00}, '{4'h8, 8'h00},
               '{4'h9, 8'h00}, '{4'ha, 8'h00}, '{4'hb, 8'h00}};
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         rchk("reset value", rows[i].sel, rows[i].exp);
      end
      wr(`FTAM_SEL_ENABLE, 8'hff);
      rchk("enable", `FTAM_SEL_ENABLE, 8'h1f);
      wr(`FTAM_SEL_WINDOW, 8'hff);
      rchk("window", `FTAM_SEL_WINDOW, 8'h03);
      wr(`FTAM_SEL_ENABLE, 8'h00);
      gpio_in <= 5'h19;
      rchk("pin status", `FTAM_SEL_PIN, 8'h19);
      rchk("flags disabled", `FTAM_SEL_FLAGS, 8'h00);
      chk("alert disabled", {7'h00, general_io_zero_oe_n}, 8'h01);
      wr(`FTAM_SEL_ENABLE, 8'h18);
      repeat (2) @(negedge clk_sys);
      chk("alert on", {7'h00, general_io_zero_oe_n}, 8'h00);
      chk("alert level", {7'h00, general_io_zero_out}, 8'h00);
      @(posedge clk_sys);
      gpio_in <= 5'h1b;
      rchk("flags pins", `FTAM_SEL_FLAGS, 8'h18);
      rchk("flags persist", `FTAM_SEL_FLAGS, 8'h10);
      @(posedge clk_sys);
      gpio_in <= 5'h1f;
      rchk("flags sticky", `FTAM_SEL_FLAGS, 8'h10);
      rchk("flags clear", `FTAM_SEL_FLAGS, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk("alert released", {7'h00, general_io_zero_oe_n}, 8'h01);
      wr(`FTAM_SEL_ENABLE, 8'h03);
      op_mode <= 2'h3;
      level_at_min <= 1'b1;
      level_at_max <= 1'b1;
      rchk("min max open loop", `FTAM_SEL_FLAGS, 8'h00);
      @(posedge clk_sys);
      op_mode <= 2'h2;
      repeat (2) @(posedge clk_sys);
      level_at_min <= 1'b0;
      level_at_max <= 1'b0;
      rchk("min max closed loop", `FTAM_SEL_FLAGS, 8'h03);
      rchk("min max clear", `FTAM_SEL_FLAGS, 8'h00);
      wr(`FTAM_SEL_DRIVE, 8'ha5);
      @(negedge clk_sys);
      chk("drive closed loop", drive_level_out, 8'h00);
      @(posedge clk_sys);
      op_mode <= 2'h3;
      repeat (2) @(negedge clk_sys);
      chk("drive open loop", drive_level_out, 8'ha5);
      repeat (50000) @(posedge clk_sys);
      rchk("drive readback", `FTAM_SEL_DRIVE, 8'ha5);
      wr(`FTAM_SEL_WINDOW, 8'h02);
      fan_period <= '{8'h08, 8'h0a, 8'h0c, 8'h14};
      repeat (1300) @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
         rchk("count", 4'(8 + i), ftam_pkg::ftam_byte_t'((QC * 4) / fan_period[i]));
      end
      wr(`FTAM_SEL_ENABLE, 8'h04);
      wr(`FTAM_SEL_WINDOW, 8'h03);
      fan_period[0] <= 8'h02;
      repeat (3700) @(posedge clk_sys);
      rchk("count saturated", 4'h8, `FTAM_COUNT_MAX);
      rchk("overflow", `FTAM_SEL_FLAGS, 8'h04);
      @(posedge clk_sys);
      fan_period[0] <= 8'h00;
      wr(`FTAM_SEL_WINDOW, 8'h00);
      repeat (400) @(posedge clk_sys);
      rchk("overflow held", `FTAM_SEL_FLAGS, 8'h04);
      rchk("overflow clear", `FTAM_SEL_FLAGS, 8'h00);
      wr(`FTAM_SEL_ENABLE, 8'h08);
      alert_select <= 1'b0;
      gpio_in <= 5'h1d;
      repeat (3) @(negedge clk_sys);
      chk("alert not selected", {7'h00, general_io_zero_oe_n}, 8'h01);
      rchk("flags unselected", `FTAM_SEL_FLAGS, 8'h08);
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      rchk("enable after reset", `FTAM_SEL_ENABLE, 8'h00);
      rchk("window after reset", `FTAM_SEL_WINDOW, 8'h02);
      rchk("flags after reset", `FTAM_SEL_FLAGS, 8'h00);
      chk("alert after reset", {7'h00, general_io_zero_oe_n}, 8'h01);
      finish_test();
   end
endmodule
